// ---- epm_defines.svh ----
// Constants for the external program memory bus block.
`ifndef EPM_DEFINES_SVH
`define EPM_DEFINES_SVH
`define EPM_CLK_MHZ 100
`define EPM_CLKS_PER_MC 4
`define EPM_RST_MC 2
`define EPM_RST_CYCLES (`EPM_CLKS_PER_MC * `EPM_RST_MC)
`define EPM_INT_LIMIT 16'h8000
`define EPM_PHASE_W 2
`define EPM_PH_ADDR 2'h0
`define EPM_PH_LATCH 2'h1
`define EPM_PH_STROBE 2'h2
`define EPM_PH_CAPTURE 2'h3
`define EPM_RSTCNT_W 4
`endif

// ---- epm_pkg.sv ----
// Types shared by the external program memory bus block.
package epm_pkg;
    // Bus sequencer states, one-hot.
    typedef enum logic [3:0] {
        EPM_IDLE = 4'h1,
        EPM_INT = 4'h2,
        EPM_EXT = 4'h4,
        EPM_DONE = 4'h8
    } epm_state_t;
endpackage

// ---- epm_reset_if.sv ----
// Interface carrying the qualified reset between the filter and the sequencer.
interface epm_reset_if;
    logic core_reset;
    modport filter (output core_reset);
    modport user (input core_reset);
endinterface

// ---- epm_reset_filter.sv ----
// Reset pin qualifier: the pin must stay high for two machine cycles.
`include "epm_defines.svh"
module epm_reset_filter
    import epm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reset_pin,
    epm_reset_if.filter rif
);
    typedef struct packed {
        logic [`EPM_RSTCNT_W-1:0] cnt;
        logic core_reset;
    } epm_rf_state_t;

    epm_rf_state_t s_q;
    epm_rf_state_t s_d;

    // Count consecutive high samples; a short glitch never resets the core.
    always_comb begin
        s_d = s_q;
        if (!reset_pin) begin
            s_d.cnt = '0;
            s_d.core_reset = 1'b0;
        end else if (s_q.cnt == `EPM_RSTCNT_W'(`EPM_RST_CYCLES - 1)) begin
            s_d.core_reset = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + `EPM_RSTCNT_W'(1);
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rif.core_reset = s_q.core_reset;
endmodule

// ---- epm_bus.sv ----
// External program memory bus: internal/external fetch steering and strobes.
//
// Overview of operation
// - Select input low forces every code fetch to external ROM.
// - Select high and address below 32 KB fetches internally, bus quiet.
// - Program store strobe asserted for every external fetch or external table read.
// - Program store strobe never pulses on internally served accesses.
// - Address latch strobe lets an external latch capture the low address.
// - Reset pin must stay high two machine cycles before core resets.
// - One machine cycle is exactly four clock periods.
// - Low address and data share one tri-stated eight-bit port, driven high and low.
// - Upper address byte is driven on a separate eight-bit port.
`include "epm_defines.svh"
module epm_bus
    import epm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reset_pin,
    input wire logic external_access_select_n,
    input wire logic fetch_req,
    input wire logic code_table_read,
    input wire logic [15:0] fetch_addr,
    input wire logic [7:0] int_rom_data,
    input wire logic [7:0] ad_in,
    output logic [7:0] ad_out,
    output logic [7:0] ad_oe,
    output logic [7:0] addr_high,
    output logic addr_latch_strobe,
    output logic program_store_strobe_n,
    output logic [15:0] int_rom_addr,
    output logic int_rom_rd,
    output logic fetch_done,
    output logic fetch_external,
    output logic [7:0] fetch_data,
    output logic core_in_reset
);
    epm_reset_if rif();

    // Qualified reset from the pin filter.
    epm_reset_filter u_rf (
        .clk(clk),
        .rst_n(rst_n),
        .reset_pin(reset_pin),
        .rif(rif)
    );

    typedef struct packed {
        epm_state_t st;
        logic [`EPM_PHASE_W-1:0] phase;
        logic [15:0] addr;
        logic [7:0] ad_out;
        logic [7:0] ad_oe;
        logic [7:0] addr_high;
        logic ale;
        logic pse_n;
        logic [15:0] irom_addr;
        logic irom_rd;
        logic done;
        logic ext;
        logic [7:0] data;
        logic in_reset;
    } epm_bus_state_t;

    epm_bus_state_t s_q;
    epm_bus_state_t s_d;
    logic go_ext;

    // Steering decision; external when select is low or above internal store.
    assign go_ext = !external_access_select_n
        || (fetch_addr >= `EPM_INT_LIMIT);

    // Each access is one machine cycle of four phases.
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.irom_rd = 1'b0;
        s_d.in_reset = rif.core_reset;
        s_d.phase = s_q.phase + `EPM_PHASE_W'(1);
        case (s_q.st)
            EPM_IDLE: begin
                s_d.phase = `EPM_PH_ADDR;
                s_d.ale = 1'b0;
                s_d.pse_n = 1'b1;
                s_d.ad_oe = 8'h00;
                // A request during qualified reset is refused and leaves no trace on any port.
                if ((fetch_req || code_table_read) && !rif.core_reset) begin
                    s_d.addr = fetch_addr;
                    s_d.ext = go_ext;
                    if (go_ext) begin
                        // Address out with latch strobe high first.
                        s_d.st = EPM_EXT;
                        s_d.ad_out = fetch_addr[7:0];
                        s_d.ad_oe = 8'hFF;
                        s_d.addr_high = fetch_addr[15:8];
                        s_d.ale = 1'b1;
                    end else begin
                        // Internal path keeps the bus and strobe quiet.
                        s_d.st = EPM_INT;
                        s_d.irom_addr = fetch_addr;
                        s_d.irom_rd = 1'b1;
                        s_d.pse_n = 1'b1;
                    end
                end
            end
            EPM_INT: begin
                if (s_q.phase == `EPM_PH_CAPTURE) begin
                    s_d.data = int_rom_data;
                    s_d.st = EPM_DONE;
                end
            end
            EPM_EXT: begin
                case (s_q.phase)
                    `EPM_PH_ADDR: begin
                        // Latch strobe falls while the address is still held.
                        s_d.ale = 1'b0;
                    end
                    `EPM_PH_LATCH: begin
                        // Release the port only after the strobe edge.
                        s_d.ad_oe = 8'h00;
                        s_d.pse_n = 1'b0;
                    end
                    `EPM_PH_STROBE: begin
                        s_d.data = ad_in;
                    end
                    default: begin
                        s_d.pse_n = 1'b1;
                        s_d.st = EPM_DONE;
                    end
                endcase
            end
            EPM_DONE: begin
                s_d.done = 1'b1;
                s_d.st = EPM_IDLE;
            end
            default: begin
                s_d.st = EPM_IDLE;
            end
        endcase
        // The qualified reset aborts any access and quiets the bus.
        if (rif.core_reset) begin
            s_d.st = EPM_IDLE;
            s_d.ale = 1'b0;
            s_d.pse_n = 1'b1;
            s_d.ad_oe = 8'h00;
            s_d.done = 1'b0;
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{st: EPM_IDLE, pse_n: 1'b1, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign ad_out = s_q.ad_out;
    assign ad_oe = s_q.ad_oe;
    assign addr_high = s_q.addr_high;
    assign addr_latch_strobe = s_q.ale;
    assign program_store_strobe_n = s_q.pse_n;
    assign int_rom_addr = s_q.irom_addr;
    assign int_rom_rd = s_q.irom_rd;
    assign fetch_done = s_q.done;
    assign fetch_external = s_q.ext;
    assign fetch_data = s_q.data;
    assign core_in_reset = s_q.in_reset;
endmodule

// ---- epm_bus_assertions.sv ----
// Concurrent checks on the ports of the external program memory bus.
`include "epm_defines.svh"
module epm_bus_checker (
    input wire logic clk, rst_n, reset_pin, external_access_select_n,
    input wire logic addr_latch_strobe, program_store_strobe_n, int_rom_rd,
    input wire logic fetch_done, fetch_external, core_in_reset,
    input wire logic [15:0] fetch_addr,
    input wire logic [7:0] ad_out,
    input wire logic [7:0] ad_oe,
    input wire logic [7:0] addr_high
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [3:0] hi_q;
    // Saturating count of pin-high samples, so a short glitch cannot qualify.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_q <= 4'h0;
        end else if (!reset_pin) begin
            hi_q <= 4'h0;
        end else begin
            hi_q <= hi_q + {3'h0, hi_q != 4'hF};
        end
    end
    ext_seq_a: assert property ($rose(addr_latch_strobe) |-> ad_oe == 8'hFF ##1
        !addr_latch_strobe && ad_oe == 8'hFF ##1 !program_store_strobe_n && ad_oe == 8'h00
        ##1 !program_store_strobe_n ##1 program_store_strobe_n ##1 fetch_done && fetch_external)
        else $error("bad external sequence");
    addr_out_a: assert property ($rose(addr_latch_strobe) |-> {addr_high, ad_out} == fetch_addr)
        else $error("bad address bytes");
    ext_route_a: assert property ($rose(addr_latch_strobe) |->
        !external_access_select_n || fetch_addr >= `EPM_INT_LIMIT) else $error("needless external");
    int_route_a: assert property (int_rom_rd |->
        external_access_select_n && fetch_addr < `EPM_INT_LIMIT) else $error("needless internal");
    int_quiet_a: assert property (int_rom_rd |->
        (program_store_strobe_n && !addr_latch_strobe && ad_oe == 8'h00) [*4]) else $error("bus moved");
    int_done_a: assert property (int_rom_rd |-> ##[3:5] fetch_done && !fetch_external)
        else $error("internal done late");
    done_pulse_a: assert property (fetch_done |=> !fetch_done) else $error("done too long");
    rst_qual_a: assert property ($rose(core_in_reset) |-> hi_q >= 4'h8) else $error("early reset");
    cover property ($rose(addr_latch_strobe));
    cover property (int_rom_rd);
    cover property ($rose(core_in_reset));
endmodule
bind epm_bus epm_bus_checker u_chk (.*);

// ---- epm_rom_model.sv ----
// External program ROM with its address latch.
module epm_rom_model (
    input wire logic clk,
    input wire logic [7:0] ad_bus,
    input wire logic [7:0] addr_high,
    input wire logic addr_latch_strobe,
    input wire logic program_store_strobe_n,
    output logic [7:0] rom_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] lo_q = 8'h00;
    logic [7:0] last_q = 8'h00;
    function automatic logic [7:0] rom_val(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction
    // The latch keeps the low byte once the port turns to data.
    always @(negedge addr_latch_strobe) lo_q = ad_bus;
    // No pull-up on the port, so a released line shows the inverse of its last level.
    always @(posedge clk) last_q <= rom_q;
    assign rom_q = !program_store_strobe_n ? rom_val({addr_high, lo_q}) : ~last_q;
endmodule

// ---- epm_tb.sv ----
// Self-checking testbench for the external program memory bus.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, reset_pin = 0, external_access_select_n = 1, fetch_req = 0;
    logic code_table_read = 0, seen;
    logic [15:0] fetch_addr = 16'h0000, int_rom_addr;
    logic [7:0] ad_out, ad_oe, addr_high, rom_q, fetch_data;
    logic addr_latch_strobe, program_store_strobe_n, int_rom_rd, fetch_done, fetch_external, core_in_reset;
    int miscompares = 0, tests_run = 0;
    typedef struct {logic s; logic t; logic [15:0] a; logic e;} epm_row_t;
    epm_row_t rows[6] = '{'{1'h1, 1'h0, 16'h0000, 1'h0}, '{1'h1, 1'h1, 16'h7FFF, 1'h0},
        '{1'h1, 1'h0, 16'h8000, 1'h1}, '{1'h0, 1'h0, 16'h0012, 1'h1},
        '{1'h0, 1'h1, 16'hFFFF, 1'h1}, '{1'h1, 1'h1, 16'hA5C3, 1'h1}};
    wire [7:0] int_rom_data = int_rom_addr[7:0] ^ 8'hC3;
    wire [7:0] ad_in = (ad_out & ad_oe) | (rom_q & ~ad_oe);
    always #5 clk = ~clk;
    epm_bus uut (.*);
    epm_rom_model u_rom (.clk(clk), .ad_bus(ad_in), .addr_high(addr_high), .rom_q(rom_q),
        .addr_latch_strobe(addr_latch_strobe), .program_store_strobe_n(program_store_strobe_n));
    task chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'h1) begin
            miscompares++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task fetch(input epm_row_t r);
        int n;
        @(posedge clk) #1;
        {external_access_select_n, fetch_addr, fetch_req, code_table_read} = {r.s, r.a, !r.t, r.t};
        @(posedge clk) #1;
        {fetch_req, code_table_read} = 2'h0;
        for (n = 0; n < 20 && fetch_done !== 1'h1; n++) @(posedge clk) #1;
        chk(n == 5, "done timing");
        chk(fetch_external === r.e, "wrong route");
        chk(fetch_data === (r.e ? u_rom.rom_val(r.a) : r.a[7:0] ^ 8'hC3), "bad data");
        $display("fetch test %h done", r.a);
    endtask
    task close_out;
        $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Watchdog: the whole sequence needs well under 300 cycles.
    initial begin
        #5000;
        miscompares++;
        close_out();
    end
    // Main sequence: reset, table of fetches, then the awkward cases.
    initial begin
        repeat (10) @(posedge clk);
        chk(program_store_strobe_n === 1'h1 && ad_oe === 8'h00 && fetch_done === 1'h0, "reset values");
        #1 rst_n = 1;
        foreach (rows[i]) fetch(rows[i]);
        reset_pin = 1;
        repeat (7) @(posedge clk);
        #1 reset_pin = 0;
        repeat (3) @(posedge clk) #1;
        chk(core_in_reset === 1'h0, "short pin reset");
        reset_pin = 1;
        repeat (11) @(posedge clk) #1;
        chk(core_in_reset === 1'h1, "pin reset missed");
        {fetch_req, seen} = 2'h2;
        repeat (8) @(posedge clk) #1 seen |= fetch_done;
        chk(seen === 1'h0, "fetch in reset");
        {fetch_req, reset_pin} = 2'h0;
        repeat (4) @(posedge clk) #1;
        chk(core_in_reset === 1'h0, "reset not left");
        fetch(rows[3]);
        $display("reset tests done");
        close_out();
    end
endmodule
